// File: pps_scan.sv
// Paper path sensor scanner: drives the four bank selects, samples the
// shared return bus and presents raw and decoded status over APB.
// Assumes an APB master on pclk and asynchronous sensor pins.
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module pps_scan
   import pps_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  sensor_return_bus,
   input  wire logic        feeder_present_n,
   output logic             option_bank_select_n,
   output logic             feeder_bank_b_select_n,
   output logic             feeder_bank_c_select_n,
   output logic             drawer_bank_select_n
);

   typedef enum logic [1:0] {
      PPS_ST_IDLE,
      PPS_ST_GAP,
      PPS_ST_SETTLE,
      PPS_ST_SAMPLE
   } pps_state_t;

   pps_state_t  state;
   logic [1:0]  bank;
   logic [7:0]  wait_cnt;
   logic [3:0]  select_n;
   logic [7:0]  pass_cnt;
   logic [1:0]  ctrl;
   logic [8:0]  synced;
   logic [7:0]  ret_sync;
   logic        feeder_present;
   logic [7:0]  snap [PPS_NUM_BANKS];
   logic [3:0]  event_flag;
   logic [3:0]  event_set;
   logic [3:0]  event_clr;
   logic        apb_setup;
   logic        apb_write;
   logic        addr_hit;
   logic [31:0] next_prdata;
   pps_option_t option_id;
   logic [9:0]  option_flags;
   logic [10:0] feeder_flags;
   logic [7:0]  drawer_flags;
   logic        scan_en;
   logic        feeder_is_large;

   assign scan_en         = ctrl[PPS_CTRL_SCAN_EN_BIT];
   assign feeder_is_large = ctrl[PPS_CTRL_LARGE_BIT];

   // Return bus and feeder-present pin cross into the pclk domain.
   pps_sync u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({feeder_present_n, sensor_return_bus}),
      .sync_out (synced)
   );

   assign ret_sync       = synced[7:0];
   assign feeder_present = ~synced[8];

   // Scan state: a dead gap cycle, then settle and sample for each bank.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= PPS_ST_IDLE;
      end else begin
         case (state)
            PPS_ST_IDLE: begin
               if (scan_en) begin
                  state <= PPS_ST_GAP;
               end
            end
            PPS_ST_GAP: begin
               if (!scan_en) begin
                  state <= PPS_ST_IDLE;
               end else begin
                  state <= PPS_ST_SETTLE;
               end
            end
            PPS_ST_SETTLE: begin
               if (wait_cnt <= 8'h01) begin
                  state <= PPS_ST_SAMPLE;
               end
            end
            PPS_ST_SAMPLE: begin
               state <= PPS_ST_GAP;
            end
            default: begin
               state <= PPS_ST_IDLE;
            end
         endcase
      end
   end

   // Bank pointer restarts at bank A when idle and advances after each sample.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank <= PPS_BANK_A;
      end else begin
         case (state)
            PPS_ST_IDLE: begin
               bank <= PPS_BANK_A;
            end
            PPS_ST_SAMPLE: begin
               bank <= bank + 2'h1;
            end
            default: begin
               bank <= bank;
            end
         endcase
      end
   end

   // Settle counter is loaded in the gap and counts down while settling.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_cnt <= 8'h00;
      end else begin
         case (state)
            PPS_ST_GAP: begin
               wait_cnt <= PPS_WAIT_CYC;
            end
            PPS_ST_SETTLE: begin
               if (wait_cnt > 8'h01) begin
                  wait_cnt <= wait_cnt - 8'h01;
               end
            end
            default: begin
               wait_cnt <= wait_cnt;
            end
         endcase
      end
   end

   // One select goes low in the gap and stays low until the sample is taken.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         select_n <= 4'hF;
      end else begin
         case (state)
            PPS_ST_GAP: begin
               if (scan_en) begin
                  select_n <= ~(4'h1 << bank);
               end else begin
                  select_n <= 4'hF;
               end
            end
            PPS_ST_SETTLE: begin
               select_n <= select_n;
            end
            default: begin
               select_n <= 4'hF;
            end
         endcase
      end
   end

   assign option_bank_select_n   = select_n[PPS_BANK_A];
   assign feeder_bank_b_select_n = select_n[PPS_BANK_B];
   assign feeder_bank_c_select_n = select_n[PPS_BANK_C];
   assign drawer_bank_select_n   = select_n[PPS_BANK_D];

   // Completed scan passes, counted on each bank D sample.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pass_cnt <= 8'h00;
      end else if (state == PPS_ST_SAMPLE && bank == PPS_BANK_D) begin
         pass_cnt <= pass_cnt + 8'h01;
      end
   end

   // Per-bank snapshot and change flag; a new change beats a clear.
   for (genvar i = 0; i < PPS_NUM_BANKS; i++) begin : g_bank
      assign event_set[i] = (state == PPS_ST_SAMPLE) && (bank == 2'(i))
                            && (ret_sync != snap[i]);
      assign event_clr[i] = apb_write && (paddr == PPS_ADDR_EVENT) && pwdata[i];

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            snap[i] <= 8'hFF;
         end else if (state == PPS_ST_SAMPLE && bank == 2'(i)) begin
            snap[i] <= ret_sync;
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            event_flag[i] <= 1'b0;
         end else begin
            event_flag[i] <= (event_flag[i] & ~event_clr[i]) | event_set[i];
         end
      end
   end

   pps_decode u_decode (
      .snap_a          (snap[0]),
      .snap_b          (snap[1]),
      .snap_c          (snap[2]),
      .snap_d          (snap[3]),
      .feeder_present  (feeder_present),
      .feeder_is_large (feeder_is_large),
      .option_id       (option_id),
      .option_flags    (option_flags),
      .feeder_flags    (feeder_flags),
      .drawer_flags    (drawer_flags)
   );

   // APB slave: zero wait states, error on unmapped addresses.
   assign apb_setup = psel && !penable;
   assign apb_write = psel && penable && pwrite;
   assign pready    = 1'b1;

   always_comb begin
      addr_hit = 1'b1;
      case (paddr)
         PPS_ADDR_CTRL, PPS_ADDR_STATUS, PPS_ADDR_RAW_A, PPS_ADDR_RAW_B,
         PPS_ADDR_RAW_C, PPS_ADDR_RAW_D, PPS_ADDR_OPTION, PPS_ADDR_FEEDER,
         PPS_ADDR_DRAWER, PPS_ADDR_EVENT: addr_hit = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   end

   assign pslverr = psel && penable && !addr_hit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= PPS_CTRL_RESET;
      end else if (apb_write && paddr == PPS_ADDR_CTRL) begin
         ctrl <= pwdata[PPS_CTRL_WIDTH-1:0];
      end
   end

   // Read data is latched in the setup cycle and held for the access cycle.
   always_comb begin
      next_prdata = 32'h00000000;
      case (paddr)
         PPS_ADDR_CTRL:   next_prdata[PPS_CTRL_WIDTH-1:0] = ctrl;
         PPS_ADDR_STATUS: begin
            next_prdata[PPS_STAT_BANK_LSB +: 2]  = bank;
            next_prdata[PPS_STAT_SCAN_BIT]       = (state != PPS_ST_IDLE);
            next_prdata[PPS_STAT_PRESENT_BIT]    = feeder_present;
            next_prdata[PPS_STAT_OPTID_LSB +: 3] = option_id;
            next_prdata[PPS_STAT_PASS_LSB +: 8]  = pass_cnt;
         end
         PPS_ADDR_RAW_A:  next_prdata[7:0]  = snap[0];
         PPS_ADDR_RAW_B:  next_prdata[7:0]  = snap[1];
         PPS_ADDR_RAW_C:  next_prdata[7:0]  = snap[2];
         PPS_ADDR_RAW_D:  next_prdata[7:0]  = snap[3];
         PPS_ADDR_OPTION: next_prdata[9:0]  = option_flags;
         PPS_ADDR_FEEDER: next_prdata[10:0] = feeder_flags;
         PPS_ADDR_DRAWER: next_prdata[7:0]  = drawer_flags;
         PPS_ADDR_EVENT:  next_prdata[3:0]  = event_flag;
         default:         next_prdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (apb_setup) begin
         prdata <= next_prdata;
      end
   end

endmodule : pps_scan

// File: pps_pkg.sv
// Constants, register map and types for the paper path sensor scanner.
// Assumes a 100 MHz pclk and an 8-bit APB byte address.
package pps_pkg;

   // Register byte offsets.
   localparam logic [7:0] PPS_ADDR_CTRL    = 8'h00;
   localparam logic [7:0] PPS_ADDR_STATUS  = 8'h04;
   localparam logic [7:0] PPS_ADDR_RAW_A   = 8'h08;
   localparam logic [7:0] PPS_ADDR_RAW_B   = 8'h0C;
   localparam logic [7:0] PPS_ADDR_RAW_C   = 8'h10;
   localparam logic [7:0] PPS_ADDR_RAW_D   = 8'h14;
   localparam logic [7:0] PPS_ADDR_OPTION  = 8'h18;
   localparam logic [7:0] PPS_ADDR_FEEDER  = 8'h1C;
   localparam logic [7:0] PPS_ADDR_DRAWER  = 8'h20;
   localparam logic [7:0] PPS_ADDR_EVENT   = 8'h24;

   // Control register fields and reset value.
   localparam int         PPS_CTRL_SCAN_EN_BIT  = 0;
   localparam int         PPS_CTRL_LARGE_BIT    = 1;
   localparam int         PPS_CTRL_WIDTH        = 2;
   localparam logic [1:0] PPS_CTRL_RESET        = 2'h0;

   // Status register field positions.
   localparam int PPS_STAT_BANK_LSB    = 0;
   localparam int PPS_STAT_SCAN_BIT    = 2;
   localparam int PPS_STAT_PRESENT_BIT = 3;
   localparam int PPS_STAT_OPTID_LSB   = 4;
   localparam int PPS_STAT_PASS_LSB    = 8;

   // Bank numbering.
   localparam int         PPS_NUM_BANKS = 4;
   localparam logic [1:0] PPS_BANK_A    = 2'h0;
   localparam logic [1:0] PPS_BANK_B    = 2'h1;
   localparam logic [1:0] PPS_BANK_C    = 2'h2;
   localparam logic [1:0] PPS_BANK_D    = 2'h3;

   // Settling time before the return bus is sampled.
   localparam int         PPS_CLK_PERIOD_NS = 10;
   localparam int         PPS_SETTLE_NS     = 200;
   localparam int         PPS_SYNC_STAGES   = 2;
   localparam int         PPS_SETTLE_CYC    =
      (PPS_SETTLE_NS + PPS_CLK_PERIOD_NS - 1) / PPS_CLK_PERIOD_NS;
   localparam logic [7:0] PPS_WAIT_CYC      = 8'(PPS_SETTLE_CYC + PPS_SYNC_STAGES);

   // Attached output option codes.
   typedef enum logic [2:0] {
      PPS_OPT_NONE    = 3'h0,
      PPS_OPT_JOBSEP  = 3'h1,
      PPS_OPT_BRIDGE  = 3'h2,
      PPS_OPT_OFFSET  = 3'h3,
      PPS_OPT_UNKNOWN = 3'h4
   } pps_option_t;

endpackage : pps_pkg

// File: pps_sync.sv
// Two-stage synchroniser for the sensor return bus and feeder-present pin.
// Assumes all inputs are asynchronous to pclk.
`timescale 1ns/100ps
module pps_sync
   import pps_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [8:0] async_in,
   output logic      [8:0] sync_out
);

   logic [8:0] stage1;

   // The first stage feeds only the second stage.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1   <= 9'h1FF;
         sync_out <= 9'h1FF;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule : pps_sync

// File: pps_decode.sv
// Decodes the four bank snapshots into normalised flags, one meaning per bit.
// Assumes snapshots are stable registers in the pclk domain.
`timescale 1ns/100ps
module pps_decode
   import pps_pkg::*;
(
   input  wire logic [7:0]  snap_a,
   input  wire logic [7:0]  snap_b,
   input  wire logic [7:0]  snap_c,
   input  wire logic [7:0]  snap_d,
   input  wire logic        feeder_present,
   input  wire logic        feeder_is_large,
   output pps_option_t      option_id,
   output logic      [9:0]  option_flags,
   output logic      [10:0] feeder_flags,
   output logic      [7:0]  drawer_flags
);

   logic is_js;
   logic is_br;
   logic is_ot;

   // Option identity from bits 1, 4 and 7.
   always_comb begin
      if (snap_a[7]) begin
         option_id = PPS_OPT_NONE;
      end else begin
         case ({snap_a[1], snap_a[4]})
            2'b00:   option_id = PPS_OPT_JOBSEP;
            2'b01:   option_id = PPS_OPT_BRIDGE;
            2'b11:   option_id = PPS_OPT_OFFSET;
            default: option_id = PPS_OPT_UNKNOWN;
         endcase
      end
   end

   assign is_js = (option_id == PPS_OPT_JOBSEP);
   assign is_br = (option_id == PPS_OPT_BRIDGE);
   assign is_ot = (option_id == PPS_OPT_OFFSET);

   // Option bank flags; bits that do not apply read zero.
   always_comb begin
      option_flags    = 10'h000;
      option_flags[0] = ~snap_a[7];
      option_flags[1] = ~snap_a[7] & snap_a[5];
      option_flags[2] = ~snap_a[7] & snap_a[2];
      option_flags[3] = (is_br & ~snap_a[0]) | ((is_js | is_ot) & snap_a[0]);
      option_flags[4] = (is_br | is_js) & snap_a[3];
      option_flags[5] = (is_br | is_ot) & snap_a[4];
      option_flags[6] = is_js & snap_a[6];
      option_flags[7] = is_ot & snap_a[6];
   end

   // Feeder bank flags, interpreted by the fitted feeder type.
   always_comb begin
      feeder_flags = 11'h000;
      if (feeder_present && !feeder_is_large) begin
         feeder_flags[0]  = ~snap_b[3];
         feeder_flags[1]  = snap_b[2];
         feeder_flags[2]  = snap_b[0];
         feeder_flags[3]  = snap_b[1];
         feeder_flags[4]  = snap_b[4];
         feeder_flags[5]  = snap_b[5];
         feeder_flags[6]  = snap_c[0];
         feeder_flags[7]  = snap_c[1];
         feeder_flags[8]  = snap_c[4];
         feeder_flags[9]  = snap_c[5];
         feeder_flags[10] = snap_c[3];
      end else if (feeder_present) begin
         feeder_flags[0]  = snap_b[0];
         feeder_flags[1]  = snap_b[6];
         feeder_flags[2]  = snap_b[7];
         feeder_flags[3]  = snap_c[0];
         feeder_flags[4]  = ~snap_c[1];
         feeder_flags[5]  = snap_c[3];
         feeder_flags[6]  = ~snap_c[4];
         feeder_flags[7]  = snap_c[2];
         feeder_flags[8]  = snap_c[5];
         feeder_flags[9]  = snap_c[6];
         feeder_flags[10] = snap_c[7];
      end
   end

   // Internal drawers use active-high flags already.
   assign drawer_flags[3:0] = snap_d[3:0];
   assign drawer_flags[7:4] = snap_d[7:4];

endmodule : pps_decode

// File: pps_scan_assertions.sv
// Checker for the bank select sequence and the APB answers of pps_scan.
// Assumes it is bound to pps_scan and sees only its ports.
`timescale 1ns/100ps
module pps_scan_assertions
   import pps_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        option_bank_select_n,
   input wire logic        feeder_bank_b_select_n,
   input wire logic        feeder_bank_c_select_n,
   input wire logic        drawer_bank_select_n
);
   logic       any_low;
   logic       acc;
   logic [7:0] low_cnt;
   assign any_low = !(option_bank_select_n && feeder_bank_b_select_n
                      && feeder_bank_c_select_n && drawer_bank_select_n);
   assign acc = psel && penable;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cnt <= 8'h00;
      end else begin
         low_cnt <= any_low ? low_cnt + 8'h01 : 8'h00;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_done(logic s);
      !s ##1 !any_low;
   endsequence
   a_one_select: assert property (
      $countones({option_bank_select_n, feeder_bank_b_select_n,
                  feeder_bank_c_select_n, drawer_bank_select_n}) >= 3)
      else $error("Two bank selects low.");
   a_settle_len: assert property ($fell(any_low) |-> low_cnt == PPS_WAIT_CYC + 8'h01)
      else $error("Select low time wrong.");
   a_low_bound: assert property (low_cnt <= PPS_WAIT_CYC + 8'h01)
      else $error("Select low too long.");
   a_order_ab: assert property (s_done(option_bank_select_n)
      |=> !feeder_bank_b_select_n || !any_low)
      else $error("Bank B does not follow A.");
   a_order_bc: assert property (s_done(feeder_bank_b_select_n)
      |=> !feeder_bank_c_select_n || !any_low)
      else $error("Bank C does not follow B.");
   a_order_cd: assert property (s_done(feeder_bank_c_select_n)
      |=> !drawer_bank_select_n || !any_low)
      else $error("Bank D does not follow C.");
   a_order_da: assert property (s_done(drawer_bank_select_n)
      |=> !option_bank_select_n || !any_low)
      else $error("Bank A does not follow D.");
   a_unmapped_rd: assert property (acc && !pwrite && paddr > 8'h24
      |-> pslverr && prdata == 32'h0)
      else $error("Unmapped read not refused.");
   a_mapped_ok: assert property (acc && paddr <= 8'h24 && paddr[1:0] == 2'b00
      |-> !pslverr && pready)
      else $error("Mapped access refused.");
   a_err_idle: assert property (!acc |-> !pslverr)
      else $error("Error outside access.");
endmodule : pps_scan_assertions
bind pps_scan pps_scan_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .prdata, .pready, .pslverr, .option_bank_select_n, .feeder_bank_b_select_n,
   .feeder_bank_c_select_n, .drawer_bank_select_n);

// File: pps_sensor_model.sv
// Sensor banks behind bus buffers, answering on the shared return bus.
// Assumes banks packs D,C,B,A from high byte to low; lag delays valid data.
`timescale 1ns/100ps
module pps_sensor_model (
   input wire logic        pclk,
   input wire logic        option_bank_select_n,
   input wire logic        feeder_bank_b_select_n,
   input wire logic        feeder_bank_c_select_n,
   input wire logic        drawer_bank_select_n,
   input wire logic [31:0] banks,
   input wire logic [3:0]  lag,
   output logic      [7:0] sensor_return_bus
);
   logic [3:0] sel;
   logic [4:0] age;
   initial sensor_return_bus = 8'h5A;
   initial age = 5'h00;
   assign sel = ~{drawer_bank_select_n, feeder_bank_c_select_n,
                  feeder_bank_b_select_n, option_bank_select_n};
   // Selected buffer drives its bank once settled; otherwise the bus toggles.
   always @(posedge pclk) begin
      age <= (sel == 4'h0) ? 5'h00 : (age == 5'h1F ? age : age + 5'h01);
      if (sel != 4'h0 && age >= {1'b0, lag})
         sensor_return_bus <= sel[0] ? banks[7:0] : sel[1] ? banks[15:8] :
                              sel[2] ? banks[23:16] : banks[31:24];
      else
         sensor_return_bus <= ~sensor_return_bus;
   end
endmodule : pps_sensor_model

// File: paper_path_sensor_scan_tb.sv
// Self-checking testbench for pps_scan with a sensor bank model.
// Assumes the register map of pps_pkg and a 100 MHz pclk.
`timescale 1ns/100ps
module paper_path_sensor_scan_tb;
   import pps_pkg::*;
   typedef struct {logic [31:0] v; logic [31:0] m; logic e;} pps_note_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, feeder_present_n;
   logic [7:0]  paddr, sensor_return_bus, a, b, c, d;
   logic [31:0] pwdata, prdata, rd_val, banks, lfsr, prev;
   logic [3:0]  lag;
   wire  [3:0]  sel_n;
   int          fails, total_checks, r, k, opt, fm;
   pps_note_t   q[$];
   pps_note_t   nt;
   pps_scan dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .sensor_return_bus, .feeder_present_n,
      .option_bank_select_n(sel_n[0]), .feeder_bank_b_select_n(sel_n[1]),
      .feeder_bank_c_select_n(sel_n[2]), .drawer_bank_select_n(sel_n[3]));
   pps_sensor_model u_far (.pclk, .option_bank_select_n(sel_n[0]),
      .feeder_bank_b_select_n(sel_n[1]), .feeder_bank_c_select_n(sel_n[2]),
      .drawer_bank_select_n(sel_n[3]), .banks, .lag, .sensor_return_bus);
   always #5 pclk = ~pclk;
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done
   task automatic cmp_word(input string nm, input logic [31:0] s, input logic [31:0] x);
      total_checks++;
      if (s !== x) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, x, s);
      end
   endtask : cmp_word
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
   endfunction : lfsr_next
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                      input logic [31:0] ev, input logic [31:0] em, input logic ee);
      int n;
      q.push_back('{ev, em, ee});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd_val = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         fails++;
         test_done();
      end
      @(posedge pclk);
   endtask : apb
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         nt = q.pop_front();
         if (pwrite === 1'b0) cmp_word("prdata", prdata & nt.m, nt.v & nt.m);
         cmp_word("pslverr", {31'h0, pslverr}, {31'h0, nt.e});
      end
   end
   task automatic wait_passes;
      logic [7:0] p0;
      int n;
      apb(1'b0, PPS_ADDR_STATUS, 32'h0, 32'h0, 32'h0, 1'b0);
      p0 = rd_val[15:8];
      n = 0;
      do begin
         apb(1'b0, PPS_ADDR_STATUS, 32'h0, 32'h0, 32'h0, 1'b0);
         n++;
      end while (rd_val[15:8] !== p0 + 8'h02 && n < 300);
      if (n >= 300) begin
         fails++;
         test_done();
      end
   endtask : wait_passes
   function automatic logic [31:0] exp_opt(input int o, input logic [7:0] x);
      if (o == 0) return 32'h0;
      return {24'h0, o == 3 && x[6], o == 1 && x[6], (o == 2 || o == 3) && x[4],
              (o == 1 || o == 2) && x[3], o != 4 && ((o == 2) ^ x[0]), x[2], x[5], 1'b1};
   endfunction : exp_opt
   function automatic logic [31:0] exp_feed(input int f, input logic [7:0] y, input logic [7:0] z);
      if (f == 1) return {21'h0, z[3], z[5], z[4], z[1], z[0], y[5], y[4], y[1], y[0], y[2], ~y[3]};
      if (f == 2) return {21'h0, z[7], z[6], z[5], z[2], ~z[4], z[3], ~z[1], z[0], y[7], y[6], y[0]};
      return 32'h0;
   endfunction : exp_feed
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      feeder_present_n = 1'b1;
      banks = 32'h0;
      lag = 4'h0;
      lfsr = 32'h310D5344;
      prev = 32'hFFFFFFFF;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, PPS_ADDR_CTRL, 32'h0, 32'h0, 32'h3, 1'b0);
      apb(1'b0, 8'h28, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
      apb(1'b1, 8'h30, 32'h1, 32'h0, 32'h0, 1'b1);
      for (r = 0; r < 15; r++) begin
         opt = r % 5;
         fm = r % 3;
         lfsr = lfsr_next(lfsr);
         {d, c, b, a} = lfsr;
         a[7] = (opt == 0);
         a[1] = (opt >= 3);
         a[4] = (opt == 2 || opt == 3);
         a[5] = (opt == 2);
         banks <= {d, c, b, a};
         lag <= lfsr[11:8];
         feeder_present_n <= (fm == 0);
         apb(1'b1, PPS_ADDR_CTRL, {30'h0, fm == 2, 1'b1}, 32'h0, 32'h0, 1'b0);
         wait_passes();
         for (k = 0; k < 4; k++)
            apb(1'b0, PPS_ADDR_RAW_A + 8'(4 * k), 32'h0, banks >> (8 * k), 32'hFF, 1'b0);
         apb(1'b0, PPS_ADDR_STATUS, 32'h0,
             {25'h0, 3'(opt), fm != 0, 3'h0}, 32'h78, 1'b0);
         apb(1'b0, PPS_ADDR_OPTION, 32'h0, exp_opt(opt, a),
             32'h3FF, 1'b0);
         apb(1'b0, PPS_ADDR_FEEDER, 32'h0, exp_feed(fm, b, c),
             32'h7FF, 1'b0);
         apb(1'b0, PPS_ADDR_DRAWER, 32'h0, {24'h0, d}, 32'hFF, 1'b0);
         apb(1'b0, PPS_ADDR_EVENT, 32'h0, {28'h0, prev[31:24] != d, prev[23:16] != c,
             prev[15:8] != b, prev[7:0] != a}, 32'hF, 1'b0);
         apb(1'b1, PPS_ADDR_EVENT, 32'hF, 32'h0, 32'h0, 1'b0);
         apb(1'b0, PPS_ADDR_EVENT, 32'h0, 32'h0, 32'hF, 1'b0);
         prev = {d, c, b, a};
      end
      apb(1'b1, PPS_ADDR_CTRL, 32'h0, 32'h0, 32'h0, 1'b0);
      repeat (30) @(posedge pclk);
      cmp_word("selects", {28'h0, sel_n}, 32'hF);
      apb(1'b0, PPS_ADDR_STATUS, 32'h0, 32'h0, 32'h7, 1'b0);
      test_done();
   end
endmodule : paper_path_sensor_scan_tb
